// ==== rtl/tsr_pkg.sv ====
// Shared constants and types for the temperature sensor register bank
package tsr_pkg;

    // --------------------------------------------------------------
    // Register select codes
    // --------------------------------------------------------------
    localparam logic [2:0] SEL_TEMP = 3'h0;
    localparam logic [2:0] SEL_CONF = 3'h1;
    localparam logic [2:0] SEL_LOW = 3'h2;
    localparam logic [2:0] SEL_HIGH = 3'h3;
    localparam logic [2:0] SEL_PERIOD = 3'h4;

    // --------------------------------------------------------------
    // Values after reset
    // --------------------------------------------------------------
    localparam logic [7:0] SELECT_RESET = 8'h00;
    localparam logic [7:0] CONF_RESET = 8'h00;
    localparam logic [7:0] PERIOD_RESET = 8'h00;
    localparam logic [15:0] TEMP_RESET = 16'h0000;
    localparam logic [15:0] LOW_RESET = 16'h4b00;
    localparam logic [15:0] HIGH_RESET = 16'h5000;

    // --------------------------------------------------------------
    // Field positions
    // --------------------------------------------------------------
    localparam int TEMP_LSB = 5;
    localparam int LIMIT_LSB = 7;
    localparam int PERIOD_MSB = 4;

    // --------------------------------------------------------------
    // Timing
    // --------------------------------------------------------------
    localparam int PERIOD_UNIT_MS = 100;
    localparam int CLK_KHZ = 125000;
    localparam int PERIOD_UNIT_CYCLES = PERIOD_UNIT_MS * CLK_KHZ;

    // --------------------------------------------------------------
    // Types
    // --------------------------------------------------------------
    typedef struct packed {
        logic [2:0] spare;
        logic [1:0] fault_count_select;
        logic alert_polarity;
        logic alert_mode_select;
        logic power_down;
    } tsr_conf_t;

    typedef struct packed {
        logic [8:0] high;
        logic [8:0] low;
    } tsr_limits_t;

endpackage : tsr_pkg

// ==== rtl/tsr_sync.sv ====
// Two-flop synchroniser for pins arriving from outside the clock domain
`timescale 1ns/10ps
module tsr_sync #(
    parameter int WIDTH = 2
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_r;

    // Bus lines idle high, so both stages reset to one
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            meta_r <= '1;
            sync_out <= '1;
        end
        else
        begin
            meta_r <= async_in;
            sync_out <= meta_r;
        end
    end
endmodule : tsr_sync

// ==== rtl/tsr_alert.sv ====
// Limit comparison, fault counting and alert pin drive
`timescale 1ns/10ps
module tsr_alert (
    input wire logic clk,
    input wire logic reset,
    input wire tsr_pkg::tsr_conf_t conf,
    input wire tsr_pkg::tsr_limits_t limits,
    input wire logic result_valid,
    input wire logic [8:0] temp9,
    input wire logic reg_read,
    output logic alert_output_out,
    output logic alert_output_oe
);
    logic active_r;
    logic armed_low_r;
    logic [2:0] fault_cnt_r;
    logic over;
    logic under;
    logic trip;

    function automatic logic [2:0] fault_target(input logic [1:0] code);
        case (code)
            2'b00: fault_target = 3'h1;
            2'b01: fault_target = 3'h2;
            2'b10: fault_target = 3'h4;
            default: fault_target = 3'h6;
        endcase
    endfunction : fault_target

    assign over = $signed(temp9) > $signed(limits.high);
    assign under = $signed(temp9) < $signed(limits.low);
    // Comparator trips on the edge opposite its state; interrupt follows the arm
    assign trip = conf.alert_mode_select ? (armed_low_r ? under : over)
                                         : (active_r ? under : over);

    // --------------------------------------------------------------
    // Alert state
    // --------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            active_r <= 1'b0;
            armed_low_r <= 1'b0;
            fault_cnt_r <= 3'h0;
        end
        else
        begin
            // Read clears and power-down clears only in interrupt mode
            if (conf.alert_mode_select && (reg_read || conf.power_down))
            begin
                active_r <= 1'b0;
            end
            // A trip in the clearing cycle still wins
            if (result_valid)
            begin
                if (trip)
                begin
                    if (fault_cnt_r + 3'h1 >= fault_target(conf.fault_count_select))
                    begin
                        fault_cnt_r <= 3'h0;
                        if (conf.alert_mode_select)
                        begin
                            active_r <= 1'b1;
                            armed_low_r <= ~armed_low_r;
                        end
                        else
                        begin
                            active_r <= ~active_r;
                        end
                    end
                    else
                    begin
                        fault_cnt_r <= fault_cnt_r + 3'h1;
                    end
                end
                else
                begin
                    fault_cnt_r <= 3'h0;
                end
            end
        end
    end

    // --------------------------------------------------------------
    // Open-drain pin: enable pulls the line low
    // --------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            alert_output_out <= 1'b0;
            alert_output_oe <= 1'b0;
        end
        else
        begin
            alert_output_out <= 1'b0;
            alert_output_oe <= conf.alert_polarity ? ~active_r : active_r;
        end
    end
endmodule : tsr_alert

// ==== rtl/tsr_top.sv ====
// Two-wire target with register bank and conversion scheduling
`timescale 1ns/10ps
//
// Behaviour
// - Select byte is eight bits, low three choose register, top five always zero.
// - Codes 0..4 pick result, configuration, low limit, high limit, sample period.
// - Select value is kept; later reads without it use the latest one.
// - Each write starts with the select byte, first byte after the address.
// - Select resets to zero, so the result reads without a select byte.
// - Configuration is eight-bit read/write, reset zero.
// - Configuration bits 7..5 are storage only, no effect.
// - Bits 4..3 pick consecutive fault count one, two, four or six.
// - Bit 2 sets alert level, one high, zero low.
// - Bit 1 picks comparator (0) or latched interrupt (1) alert behaviour.
// - Bit 0 set means power-down, no conversions.
// - Result register is read-only and loads at each conversion end.
// - Result is 11-bit two's complement, left-justified, 0.125 degree steps.
// - Result reads as two bytes, high first, low five bits zero.
// - A read stopping after the first result byte is accepted.
// - Upper nine result bits form the half-degree value used for comparison.
// - Result reads zero until the first conversion completes.
// - Low limit is sixteen-bit read/write, reset 4b00h.
// - Limits keep nine upper bits; the lower seven read zero.
// - Sample period is eight-bit read/write giving 100 ms by default.
// - Conversion starts every period field times 100 ms; zero acts as one.
module tsr_top #(
    parameter logic [6:0] TARGET_ADDR = 7'h48,
    parameter int PERIOD_UNIT_CYCLES = tsr_pkg::PERIOD_UNIT_CYCLES
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic [10:0] conv_result,
    input wire logic conv_done,
    output logic conv_start,
    output logic alert_output_out,
    output logic alert_output_oe
);
    typedef enum {
        ST_IDLE,
        ST_ADDR,
        ST_ADDR_ACK,
        ST_WR_BYTE,
        ST_WR_ACK,
        ST_RD_BYTE,
        ST_RD_ACK
    } tsr_state_t;

    tsr_state_t state_r;
    logic [1:0] pins_s;
    logic scl_s;
    logic sda_s;
    logic scl_d_r;
    logic sda_d_r;
    logic scl_rise;
    logic scl_fall;
    logic bus_start;
    logic bus_stop;
    logic [3:0] bit_cnt_r;
    logic [7:0] shift_r;
    logic [1:0] byte_idx_r;
    logic rnw_r;
    logic rd_lsb_r;
    logic reg_read_r;
    logic wr_done;
    logic [7:0] select_r;
    tsr_pkg::tsr_conf_t conf_r;
    logic [7:0] period_r;
    logic [15:0] temp_r;
    tsr_pkg::tsr_limits_t limits_r;
    logic [7:0] stage_r;
    logic result_valid_r;
    logic [23:0] unit_cnt_r;
    logic [4:0] slot_cnt_r;
    logic [4:0] period_eff;
    logic kick_r;
    logic [7:0] rd_next;

    function automatic logic [7:0] read_byte(
        input logic [2:0] sel,
        input logic lsb,
        input logic [15:0] temp,
        input tsr_pkg::tsr_conf_t conf,
        input tsr_pkg::tsr_limits_t lim,
        input logic [7:0] period
    );
        logic [15:0] word;
        word = 16'h0000;
        case (sel)
            tsr_pkg::SEL_TEMP: word = temp;
            tsr_pkg::SEL_CONF: word = {conf, conf};
            tsr_pkg::SEL_LOW: word = {lim.low, 7'h00};
            tsr_pkg::SEL_HIGH: word = {lim.high, 7'h00};
            tsr_pkg::SEL_PERIOD: word = {period, period};
            default: word = 16'h0000;
        endcase
        read_byte = lsb ? word[7:0] : word[15:8];
    endfunction : read_byte

    assign rd_next = read_byte(select_r[2:0], rd_lsb_r, temp_r, conf_r, limits_r,
                               period_r);

    // --------------------------------------------------------------
    // Pin sampling and bus conditions
    // --------------------------------------------------------------
    tsr_sync #(
        .WIDTH(2)
    ) u_sync (
        .clk(clk),
        .reset(reset),
        .async_in({scl_in, sda_in}),
        .sync_out(pins_s)
    );

    assign scl_s = pins_s[1];
    assign sda_s = pins_s[0];

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            scl_d_r <= 1'b1;
            sda_d_r <= 1'b1;
        end
        else
        begin
            scl_d_r <= scl_s;
            sda_d_r <= sda_s;
        end
    end

    assign scl_rise = scl_s & ~scl_d_r;
    assign scl_fall = ~scl_s & scl_d_r;
    assign bus_start = scl_s & scl_d_r & sda_d_r & ~sda_s;
    assign bus_stop = scl_s & scl_d_r & ~sda_d_r & sda_s;
    assign wr_done = (state_r == ST_WR_BYTE) && scl_fall && (bit_cnt_r == 4'h8);

    // --------------------------------------------------------------
    // Bus protocol engine
    // --------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            state_r <= ST_IDLE;
            bit_cnt_r <= 4'h0;
            shift_r <= 8'h00;
            byte_idx_r <= 2'h0;
            rnw_r <= 1'b0;
            rd_lsb_r <= 1'b0;
            reg_read_r <= 1'b0;
            sda_out <= 1'b0;
            sda_oe <= 1'b0;
        end
        else
        begin
            reg_read_r <= 1'b0;
            sda_out <= 1'b0;
            if (bus_start)
            begin
                state_r <= ST_ADDR;
                bit_cnt_r <= 4'h0;
                byte_idx_r <= 2'h0;
                sda_oe <= 1'b0;
            end
            else if (bus_stop)
            begin
                state_r <= ST_IDLE;
                sda_oe <= 1'b0;
            end
            else
            begin
                case (state_r)
                    ST_ADDR, ST_WR_BYTE:
                    begin
                        if (scl_rise)
                        begin
                            shift_r <= {shift_r[6:0], sda_s};
                            bit_cnt_r <= bit_cnt_r + 4'h1;
                        end
                        else if (scl_fall && bit_cnt_r == 4'h8)
                        begin
                            bit_cnt_r <= 4'h0;
                            if (state_r == ST_WR_BYTE)
                            begin
                                // Every data byte is acknowledged, result writes too
                                sda_oe <= 1'b1;
                                state_r <= ST_WR_ACK;
                                if (byte_idx_r != 2'h3)
                                begin
                                    byte_idx_r <= byte_idx_r + 2'h1;
                                end
                            end
                            else if (shift_r[7:1] == TARGET_ADDR)
                            begin
                                sda_oe <= 1'b1;
                                rnw_r <= shift_r[0];
                                state_r <= ST_ADDR_ACK;
                            end
                            else
                            begin
                                state_r <= ST_IDLE;
                            end
                        end
                    end
                    ST_WR_ACK:
                    begin
                        if (scl_fall)
                        begin
                            sda_oe <= 1'b0;
                            state_r <= ST_WR_BYTE;
                        end
                    end
                    ST_ADDR_ACK, ST_RD_ACK:
                    begin
                        if (state_r == ST_RD_ACK && scl_rise && sda_s)
                        begin
                            // Controller ended the read, possibly after one byte
                            state_r <= ST_IDLE;
                        end
                        else if (scl_fall)
                        begin
                            if (state_r == ST_ADDR_ACK && !rnw_r)
                            begin
                                sda_oe <= 1'b0;
                                state_r <= ST_WR_BYTE;
                            end
                            else
                            begin
                                // Reads use the select latched earlier
                                shift_r <= rd_next;
                                sda_oe <= ~rd_next[7];
                                rd_lsb_r <= ~rd_lsb_r;
                                bit_cnt_r <= 4'h0;
                                state_r <= ST_RD_BYTE;
                            end
                        end
                        if (state_r == ST_ADDR_ACK && scl_fall && rnw_r)
                        begin
                            reg_read_r <= 1'b1;
                        end
                        if (state_r == ST_ADDR_ACK)
                        begin
                            // Each read starts with the most significant byte
                            rd_lsb_r <= scl_fall ? 1'b1 : 1'b0;
                        end
                    end
                    ST_RD_BYTE:
                    begin
                        if (scl_rise)
                        begin
                            bit_cnt_r <= bit_cnt_r + 4'h1;
                        end
                        else if (scl_fall)
                        begin
                            if (bit_cnt_r == 4'h8)
                            begin
                                sda_oe <= 1'b0;
                                state_r <= ST_RD_ACK;
                            end
                            else
                            begin
                                shift_r <= {shift_r[6:0], 1'b0};
                                sda_oe <= ~shift_r[6];
                            end
                        end
                    end
                    default:
                    begin
                        sda_oe <= 1'b0;
                    end
                endcase
            end
        end
    end

    // --------------------------------------------------------------
    // Register writes
    // --------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            select_r <= tsr_pkg::SELECT_RESET;
            conf_r <= tsr_pkg::CONF_RESET;
            period_r <= tsr_pkg::PERIOD_RESET;
            limits_r.high <= tsr_pkg::HIGH_RESET[15:tsr_pkg::LIMIT_LSB];
            limits_r.low <= tsr_pkg::LOW_RESET[15:tsr_pkg::LIMIT_LSB];
            stage_r <= 8'h00;
        end
        else if (wr_done)
        begin
            case (byte_idx_r)
                2'h0:
                begin
                    select_r <= {5'h00, shift_r[2:0]};
                end
                2'h1:
                begin
                    case (select_r[2:0])
                        tsr_pkg::SEL_CONF: conf_r <= shift_r;
                        tsr_pkg::SEL_PERIOD: period_r <= shift_r;
                        tsr_pkg::SEL_LOW, tsr_pkg::SEL_HIGH: stage_r <= shift_r;
                        default: stage_r <= stage_r;
                    endcase
                end
                2'h2:
                begin
                    // Limit changes take effect only once the low byte lands
                    if (select_r[2:0] == tsr_pkg::SEL_LOW)
                    begin
                        limits_r.low <= {stage_r, shift_r[7]};
                    end
                    else if (select_r[2:0] == tsr_pkg::SEL_HIGH)
                    begin
                        limits_r.high <= {stage_r, shift_r[7]};
                    end
                end
                default:
                begin
                    stage_r <= stage_r;
                end
            endcase
        end
    end

    // --------------------------------------------------------------
    // Result register
    // --------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            temp_r <= tsr_pkg::TEMP_RESET;
            result_valid_r <= 1'b0;
        end
        else
        begin
            result_valid_r <= conv_done;
            if (conv_done)
            begin
                temp_r <= {conv_result, 5'h00};
            end
        end
    end

    // --------------------------------------------------------------
    // Conversion scheduling
    // --------------------------------------------------------------
    assign period_eff = (period_r[tsr_pkg::PERIOD_MSB:0] == 5'h00) ? 5'h01
                                                                   : period_r[4:0];

    // A conversion starts at once after reset and on leaving power-down
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            unit_cnt_r <= 24'h000000;
            slot_cnt_r <= 5'h00;
            kick_r <= 1'b1;
            conv_start <= 1'b0;
        end
        else
        begin
            conv_start <= 1'b0;
            if (conf_r.power_down)
            begin
                unit_cnt_r <= 24'h000000;
                slot_cnt_r <= 5'h00;
                kick_r <= 1'b1;
            end
            else if (kick_r)
            begin
                kick_r <= 1'b0;
                conv_start <= 1'b1;
            end
            else if (unit_cnt_r == 24'(PERIOD_UNIT_CYCLES - 1))
            begin
                unit_cnt_r <= 24'h000000;
                if (slot_cnt_r + 5'h01 >= period_eff)
                begin
                    slot_cnt_r <= 5'h00;
                    conv_start <= 1'b1;
                end
                else
                begin
                    slot_cnt_r <= slot_cnt_r + 5'h01;
                end
            end
            else
            begin
                unit_cnt_r <= unit_cnt_r + 24'h000001;
            end
        end
    end

    // --------------------------------------------------------------
    // Alert logic on the half-degree value
    // --------------------------------------------------------------
    tsr_alert u_alert (
        .clk(clk),
        .reset(reset),
        .conf(conf_r),
        .limits(limits_r),
        .result_valid(result_valid_r),
        .temp9(temp_r[15:tsr_pkg::LIMIT_LSB]),
        .reg_read(reg_read_r),
        .alert_output_out(alert_output_out),
        .alert_output_oe(alert_output_oe)
    );
endmodule : tsr_top

// ==== test/tsr_i2c_ctrl.sv ====
// Behavioural two-wire bus controller for the register bank
`timescale 1ns/10ps
module tsr_i2c_ctrl (
    output logic scl,
    output logic sda_pull,
    input wire logic sda_line
);
    // Both pins idle released, so the wire rests at the pull-up level
    initial
    begin
        scl = 1'b1;
        sda_pull = 1'b0;
    end
    task automatic start_c();
        sda_pull = 1'b0;
        #31.25 scl = 1'b1;
        #31.25 sda_pull = 1'b1;
        #31.25 scl = 1'b0;
        // Data must not move in the same step as the clock fall
        #31.25;
    endtask : start_c
    task automatic stop_c();
        sda_pull = 1'b1;
        #31.25 scl = 1'b1;
        #31.25 sda_pull = 1'b0;
        #62.5;
    endtask : stop_c
    // Eight data bits then the acknowledge slot; data moves only while the clock is low
    task automatic xfer(input logic [8:0] d, output logic [8:0] q);
        for (int i = 8; i >= 0; i--)
        begin
            sda_pull = !d[i];
            #31.25 scl = 1'b1;
            #31.25 q[i] = sda_line;
            #31.25 scl = 1'b0;
            #31.25;
        end
    endtask : xfer
endmodule : tsr_i2c_ctrl

// ==== test/tsr_top_asserts.sv ====
// Port checks for the sensor register bank
`timescale 1ns/10ps
module tsr_top_asserts #(
    parameter int PERIOD_UNIT_CYCLES = 50
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic scl_in,
    input wire logic sda_out,
    input wire logic sda_oe,
    input wire logic conv_start,
    input wire logic alert_output_out,
    input wire logic alert_output_oe
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);
    // Large after reset so the power-up start never looks short
    int gap_r;
    always_ff @(posedge clk)
    begin
        gap_r <= reset ? 1000000 : (conv_start ? 0 : gap_r + 1);
    end
    sda_drain_a: assert property (!sda_out)
        else $error("sda driven high");
    alert_drain_a: assert property (!alert_output_out)
        else $error("alert driven high");
    start_pulse_a: assert property (conv_start |=> !conv_start)
        else $error("start longer than one cycle");
    start_gap_a: assert property (conv_start |-> gap_r >= PERIOD_UNIT_CYCLES - 1)
        else $error("starts too close");
    boot_start_a: assert property ($fell(reset) |-> ##[0:2] conv_start)
        else $error("no start after reset");
    boot_idle_a: assert property ($fell(reset) |-> !sda_oe && !alert_output_oe)
        else $error("pins active after reset");
    sda_edge_a: assert property ($changed(sda_oe) |-> !scl_in)
        else $error("sda moved while clock high");
    ack_hold_a: assert property ($rose(sda_oe) |=> sda_oe [*8])
        else $error("sda pulse too short");
endmodule : tsr_top_asserts

// ==== test/tsr_top_tb.sv ====
// Self-checking bench for the sensor register bank
`timescale 1ns/10ps
module tsr_top_tb;
    typedef struct packed {logic wr; logic [2:0] sel; logic [15:0] d; logic [15:0] e;} tsr_row_t;
    logic clk, reset, scl, pull, conv_done, engine_on, sda_oe, conv_start, alert_oe;
    logic [10:0] conv_result, temp_val;
    wire sda = !sda_oe && !pull;
    int n_mismatch, check_count, starts;
    tsr_row_t rows [10] = '{
        '{1'b0, 3'h0, 16'h0000, 16'h0000},
        '{1'b0, 3'h1, 16'h0000, 16'h0000},
        '{1'b0, 3'h2, 16'h0000, 16'h4b00},
        '{1'b0, 3'h3, 16'h0000, 16'h5000},
        '{1'b0, 3'h4, 16'h0000, 16'h0000},
        '{1'b1, 3'h1, 16'hfe00, 16'hfefe},
        '{1'b1, 3'h2, 16'h1234, 16'h1200},
        '{1'b1, 3'h3, 16'habcd, 16'hab80},
        '{1'b1, 3'h4, 16'h2200, 16'h2222},
        '{1'b1, 3'h0, 16'h5555, 16'hc920}};
    tsr_top #(.PERIOD_UNIT_CYCLES(50)) u_tsr_top (.clk(clk), .reset(reset), .scl_in(scl),
        .sda_in(sda), .sda_out(), .sda_oe(sda_oe), .conv_result(conv_result),
        .conv_done(conv_done), .conv_start(conv_start), .alert_output_out(),
        .alert_output_oe(alert_oe));
    tsr_i2c_ctrl u_tsr_i2c_ctrl (.scl(scl), .sda_pull(pull), .sda_line(sda));
    // Conversion engine stand-in answers one cycle after each start made while engine_on is set
    always @(posedge clk)
    begin
        conv_done <= conv_start && engine_on;
        conv_result <= temp_val;
        starts <= starts + int'(conv_start);
    end
    task automatic check16(input string what, input logic [15:0] e, input logic [15:0] s);
        check_count++;
        if (s !== e)
        begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", what, e, s);
        end
    endtask : check16
    task automatic put(input logic [7:0] b);
        logic [8:0] q;
        u_tsr_i2c_ctrl.xfer({b, 1'b1}, q);
        check16("ack", 16'h0000, {15'h0000, q[0]});
    endtask : put
    // The select byte always leads a write; reads of another register select first
    task automatic wr(input logic [2:0] sel, input logic [15:0] d, input int n);
        u_tsr_i2c_ctrl.start_c();
        put(8'h90);
        put({5'h00, sel});
        if (n > 0) put(d[15:8]);
        if (n > 1) put(d[7:0]);
        u_tsr_i2c_ctrl.stop_c();
    endtask : wr
    task automatic rd(input int n, output logic [15:0] v);
        logic [8:0] q;
        u_tsr_i2c_ctrl.start_c();
        put(8'h91);
        v = 16'h0000;
        for (int i = 0; i < n; i++)
        begin
            u_tsr_i2c_ctrl.xfer({8'hff, i == n - 1}, q);
            v = {v[7:0], q[8:1]};
        end
        u_tsr_i2c_ctrl.stop_c();
    endtask : rd
    task automatic do_reset();
        logic [15:0] v;
        engine_on <= 1'b0;
        reset <= 1'b1;
        repeat (5) @(posedge clk);
        reset <= 1'b0;
        rd(2, v);
        check16("temp at reset", 16'h0000, v);
    endtask : do_reset
    task automatic complete_run();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : complete_run
    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    initial
    begin
        #500000;
        n_mismatch++;
        complete_run();
    end
    initial
    begin
        logic [15:0] v;
        int n, s0;
        {reset, conv_done, engine_on, conv_result, starts} = {1'b1, 2'b00, 11'h000, 32'h0};
        {n_mismatch, check_count, temp_val} = {32'h0, 32'h0, 11'h649};
        do_reset();
        foreach (rows[i])
        begin
            engine_on <= rows[i].wr;
            n = (rows[i].sel inside {3'h1, 3'h4}) ? 1 : 2;
            if (rows[i].wr) wr(rows[i].sel, rows[i].d, n);
            wr(rows[i].sel, 16'h0000, 0);
            rd(2, v);
            check16("reg", rows[i].e, v);
        end
        wr(3'h0, 16'h0000, 0);
        rd(1, v);
        check16("temp msb", 16'h00c9, v);
        rd(2, v);
        check16("temp repeat", 16'hc920, v);
        temp_val <= 11'h0c8;
        repeat (150) @(posedge clk);
        rd(2, v);
        check16("temp new", 16'h1900, v);
        wr(3'h1, 16'h0100, 1);
        s0 = starts;
        repeat (300) @(posedge clk);
        check16("starts off", 16'h0000, 16'(starts - s0));
        wr(3'h1, 16'h0000, 1);
        repeat (200) @(posedge clk);
        s0 = starts;
        repeat (1000) @(posedge clk);
        check16("starts on", 16'h000a, 16'(starts - s0));
        // 25 C is above the high limit left by the rows, so the comparator is active
        check16("alert low", 16'h0001, {15'h0000, alert_oe});
        rd(2, v);
        check16("alert kept", 16'h0001, {15'h0000, alert_oe});
        wr(3'h1, 16'h0400, 1);
        repeat (10) @(posedge clk);
        check16("alert high", 16'h0000, {15'h0000, alert_oe});
        do_reset();
        complete_run();
    end
endmodule : tsr_top_tb
bind tsr_top tsr_top_asserts #(.PERIOD_UNIT_CYCLES(PERIOD_UNIT_CYCLES)) u_tsr_top_asserts (
    .clk(clk), .reset(reset), .scl_in(scl_in), .sda_out(sda_out), .sda_oe(sda_oe),
    .conv_start(conv_start), .alert_output_out(alert_output_out),
    .alert_output_oe(alert_output_oe));
